// ===== common/sodc_defines.svh
`ifndef SODC_DEFINES_SVH
`define SODC_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SODC_A_CFG0 8'h00
`define SODC_A_OUT 8'h04
`define SODC_A_DIV 8'h08
`define SODC_A_CAL 8'h0c
`define SODC_A_STAT 8'h10
`define SODC_A_FACT 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SODC_CFG0_TRIG 0
`define SODC_CFG0_SLEEP 1
`define SODC_CFG0_FAST 2
`define SODC_CFG0_CFORCE 3
`define SODC_CFG0_AFORCE 4
`define SODC_CFG0_BFORCE 5
`define SODC_OUT_ASRC 0
`define SODC_OUT_BSRC 2
`define SODC_OUT_DBL 4
`define SODC_OUT_DIVPD 5
`define SODC_OUT_LVLA 8
`define SODC_OUT_LVLB 16
`define SODC_CAL_CORE 0
`define SODC_CAL_AMP 8
`define SODC_CAL_BAND 24
`define SODC_ST_BUSY 0
`define SODC_ST_PDN 1
`define SODC_ST_DIVPWR 2
`define SODC_ST_DBL 3
`define SODC_ST_BADDIV 4
`define SODC_ST_RECAL 5
`define SODC_ST_RATIO 16
`define SODC_FA_F0 0
`define SODC_FA_F1 8
`define SODC_FA_F2 16
`define SODC_FA_F3 24

// ----------------------------------------
// Source select codes and reset values
// ----------------------------------------
`define SODC_SRC_DIV 2'h0
`define SODC_SRC_VCO 2'h1
`define SODC_SRC_ALT 2'h2
`define SODC_RST_CFG0 6'h00
`define SODC_RST_OUT 22'h000005
`define SODC_RST_DIV 5'h00
`define SODC_RST_CAL 32'h00000000
`define SODC_DIV_CODES 5'h12
`define SODC_LVL_DUP_HI 2'h2
`define SODC_LVL_DUP_LO 2'h1
`define SODC_CAL_CYCLES 16'h0040

`endif

// ===== common/sodc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sodc_div_if;
  import sodc_pkg::*;
  logic [4:0] code;
  sodc_factor_t factor0;
  sodc_factor_t factor1;
  sodc_factor_t factor2;
  sodc_factor_t factor3;
  sodc_ratio_t ratio;
  logic invalid;
  modport dec (input code, output factor0, factor1, factor2, factor3, ratio, invalid);
  modport user (output code, input factor0, factor1, factor2, factor3, ratio, invalid);
endinterface : sodc_div_if
`default_nettype wire

// ===== common/sodc_pkg.sv
package sodc_pkg;
  typedef logic [4:0] sodc_factor_t;
  typedef logic [9:0] sodc_ratio_t;
  typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} sodc_cal_state_t;
endpackage : sodc_pkg

// ===== core/sodc_div_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "sodc_defines.svh"
module sodc_div_decode
  import sodc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  sodc_div_if.dec div
);

  // ----------------------------------------
  // Segment lookup, stages one to three
  // ----------------------------------------
  function automatic logic [14:0] segLookup(input logic [4:0] code);
    logic [14:0] s;
    s = {5'h01, 5'h01, 5'h01};
    case (code)
      5'h00: s = {5'h01, 5'h01, 5'h01};
      5'h01: s = {5'h02, 5'h01, 5'h01};
      5'h02: s = {5'h03, 5'h01, 5'h01};
      5'h03: s = {5'h02, 5'h02, 5'h01};
      5'h04: s = {5'h03, 5'h02, 5'h01};
      5'h05: s = {5'h02, 5'h04, 5'h01};
      5'h06: s = {5'h02, 5'h06, 5'h01};
      5'h07: s = {5'h02, 5'h08, 5'h01};
      5'h08: s = {5'h03, 5'h08, 5'h01};
      5'h09: s = {5'h02, 5'h08, 5'h02};
      5'h0a: s = {5'h03, 5'h06, 5'h02};
      5'h0b: s = {5'h03, 5'h08, 5'h02};
      5'h0c: s = {5'h02, 5'h08, 5'h04};
      5'h0d: s = {5'h02, 5'h08, 5'h06};
      5'h0e: s = {5'h02, 5'h08, 5'h08};
      5'h0f: s = {5'h03, 5'h08, 5'h08};
      5'h10: s = {5'h02, 5'h08, 5'h10};
      5'h11: s = {5'h03, 5'h08, 5'h10};
      default: s = {5'h01, 5'h01, 5'h01};
    endcase
    return s;
  endfunction : segLookup

  sodc_factor_t f1_q, f1_d, f2_q, f2_d, f3_q, f3_d;
  logic [14:0] seg;
  logic isValid;

  always_comb begin
    seg = segLookup(div.code);
    isValid = (div.code < `SODC_DIV_CODES);
    f1_d = f1_q;
    f2_d = f2_q;
    f3_d = f3_q;
    if (isValid) begin // Bad code keeps last good factors
      f1_d = seg[14:10];
      f2_d = seg[9:5];
      f3_d = seg[4:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      f1_q <= 5'h01;
      f2_q <= 5'h01;
      f3_q <= 5'h01;
    end else begin
      f1_q <= f1_d;
      f2_q <= f2_d;
      f3_q <= f3_d;
    end
  end

  assign div.factor0 = 5'h02;
  assign div.factor1 = f1_q;
  assign div.factor2 = f2_q;
  assign div.factor3 = f3_q;
  // Four cascaded stages multiply
  assign div.ratio = 10'(div.factor0) * 10'(f1_q) * 10'(f2_q) * 10'(f3_q);
  assign div.invalid = ~isValid;

endmodule : sodc_div_decode
`default_nettype wire

// ===== core/sodc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sodc_defines.svh"
// Overview of operation
// - Divider ratio is the product of four cascaded stage factors.
// - Five-bit divider code 0..17 picks table factors; 18..31 invalid.
// - Divider powered when A selects divider or B selects divider/frame ref.
// - Doubled VCO only reachable on output A, up to 19 GHz.
// - Level codes 32..47 act like 16..31.
// - Chip enable pin or sleep bit controls powerdown.
// - Full calibration always runs from supplied start values.
// - Writing first config word with trigger set starts calibration.
module sodc_top
  import sodc_pkg::*;
#(
  parameter logic [15:0] CAL_CYCLES = `SODC_CAL_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chipEnable,
  output logic powerDown,
  output logic divPowerOn,
  output logic doublerOn,
  output logic [1:0] outASource,
  output logic [1:0] outBSource,
  output logic [5:0] levelA,
  output logic [5:0] levelB,
  output logic [4:0] stageFactor0,
  output logic [4:0] stageFactor1,
  output logic [4:0] stageFactor2,
  output logic [4:0] stageFactor3,
  output logic [9:0] divRatio,
  output logic calStart,
  output logic calBusy,
  output logic fastRecalOn,
  output logic coreForce,
  output logic amplitudeForce,
  output logic bandForce,
  output logic [2:0] coreSelect,
  output logic [8:0] amplitudeStartCode,
  output logic [7:0] bandStartCode
);

  // A zero count would wrap and stay in the running state for 65536 cycles
  if (CAL_CYCLES == 16'h0000) begin : g_cal_check
    $error("CAL_CYCLES must be at least one");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Upper duplicate band folds onto 16..31
  function automatic logic [5:0] foldLevel(input logic [5:0] lvl);
    return (lvl[5:4] == `SODC_LVL_DUP_HI) ? {`SODC_LVL_DUP_LO, lvl[3:0]} : lvl;
  endfunction : foldLevel

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [5:0] cfg0_q, cfg0_d;
  logic [21:0] out_q, out_d;
  logic [4:0] div_q, div_d;
  logic [31:0] cal_q, cal_d;
  logic wrPend_q, wrPend_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  sodc_cal_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic start_q, start_d;
  logic pdn_q, pdn_d;
  logic recal_q, recal_d;
  logic addrPhase, trigWrite, pdnNow, divPwr, dblOn;
  logic [31:0] statusWord, factWord;

  sodc_div_if divBus ();

  sodc_div_decode u_dec (
    .mclk(mclk),
    .reset(reset),
    .div(divBus.dec)
  );

  assign divBus.code = div_q;

  // ----------------------------------------
  // Register bus and configuration
  // ----------------------------------------
  always_comb begin
    addrPhase = hsel && hready && htrans[1];
    addr_d = addrPhase ? haddr[7:0] : addr_q;
    wrPend_d = addrPhase && hwrite;
    cfg0_d = cfg0_q;
    out_d = out_q;
    div_d = div_q;
    cal_d = cal_q;
    trigWrite = 1'b0;
    if (wrPend_q) begin
      case (addr_q)
        `SODC_A_CFG0: begin
          cfg0_d = hwdata[5:0];
          trigWrite = hwdata[`SODC_CFG0_TRIG];
        end
        `SODC_A_OUT: out_d = hwdata[21:0];
        `SODC_A_DIV: div_d = hwdata[4:0];
        `SODC_A_CAL: cal_d = hwdata;
        default: ;
      endcase
    end
    // Read mux sees the next values so a write just before is visible
    rdata_d = rdata_q;
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        `SODC_A_CFG0: rdata_d = {26'h0, cfg0_d};
        `SODC_A_OUT: rdata_d = {10'h0, out_d};
        `SODC_A_DIV: rdata_d = {27'h0, div_d};
        `SODC_A_CAL: rdata_d = {cal_d[31:24], 7'h0, cal_d[16:8], 5'h0, cal_d[2:0]};
        `SODC_A_STAT: rdata_d = statusWord;
        `SODC_A_FACT: rdata_d = factWord;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg0_q <= `SODC_RST_CFG0;
      out_q <= `SODC_RST_OUT;
      div_q <= `SODC_RST_DIV;
      cal_q <= `SODC_RST_CAL;
      wrPend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      cfg0_q <= cfg0_d;
      out_q <= out_d;
      div_q <= div_d;
      cal_q <= cal_d;
      wrPend_q <= wrPend_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Output path decode
  // ----------------------------------------
  always_comb begin
    // Own powerdown bit cannot override a selected divider
    divPwr = (out_q[`SODC_OUT_ASRC +: 2] == `SODC_SRC_DIV) ||
             (out_q[`SODC_OUT_BSRC +: 2] == `SODC_SRC_DIV) ||
             (out_q[`SODC_OUT_BSRC +: 2] == `SODC_SRC_ALT);
    // Code 2 on B means frame ref, never doubler
    dblOn = (out_q[`SODC_OUT_ASRC +: 2] == `SODC_SRC_ALT) && out_q[`SODC_OUT_DBL];
    pdnNow = !chipEnable || cfg0_q[`SODC_CFG0_SLEEP];
    statusWord = {6'h0, divBus.ratio, 10'h0, recal_q, divBus.invalid, dblOn, divPwr, pdn_q,
                  (state_q == CAL_RUN)};
    factWord = {3'h0, divBus.factor3, 3'h0, divBus.factor2, 3'h0, divBus.factor1,
                3'h0, divBus.factor0};
  end

  // ----------------------------------------
  // Calibration and powerdown tracking
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    start_d = trigWrite;
    pdn_d = pdnNow;
    recal_d = recal_q;
    if (trigWrite) begin
      recal_d = 1'b0;
    end
    if (pdn_q && !pdnNow) begin // Exit sets, and wins over a same-cycle trigger
      recal_d = 1'b1;
    end
    case (state_q)
      CAL_IDLE: begin
        if (trigWrite) begin
          state_d = CAL_RUN;
          cnt_d = CAL_CYCLES;
        end
      end
      CAL_RUN: begin
        // Full sweep always runs; start codes only seed it
        if (trigWrite) begin
          cnt_d = CAL_CYCLES;
        end else if (cnt_q == 16'h0001) begin
          state_d = CAL_IDLE;
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        state_d = CAL_IDLE;
        cnt_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= CAL_IDLE;
      cnt_q <= 16'h0000;
      start_q <= 1'b0;
      pdn_q <= 1'b0;
      recal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
      pdn_q <= pdn_d;
      recal_q <= recal_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign powerDown = pdn_q;
  assign divPowerOn = divPwr;
  assign doublerOn = dblOn;
  assign outASource = out_q[`SODC_OUT_ASRC +: 2];
  assign outBSource = out_q[`SODC_OUT_BSRC +: 2];
  assign levelA = foldLevel(out_q[`SODC_OUT_LVLA +: 6]);
  assign levelB = foldLevel(out_q[`SODC_OUT_LVLB +: 6]);
  assign stageFactor0 = divBus.factor0;
  assign stageFactor1 = divBus.factor1;
  assign stageFactor2 = divBus.factor2;
  assign stageFactor3 = divBus.factor3;
  assign divRatio = divBus.ratio;
  assign calStart = start_q;
  assign calBusy = (state_q == CAL_RUN);
  assign fastRecalOn = cfg0_q[`SODC_CFG0_FAST];
  assign coreForce = cfg0_q[`SODC_CFG0_CFORCE];
  assign amplitudeForce = cfg0_q[`SODC_CFG0_AFORCE];
  assign bandForce = cfg0_q[`SODC_CFG0_BFORCE];
  assign coreSelect = cal_q[`SODC_CAL_CORE +: 3];
  assign amplitudeStartCode = cal_q[`SODC_CAL_AMP +: 9];
  assign bandStartCode = cal_q[`SODC_CAL_BAND +: 8];

endmodule : sodc_top
`default_nettype wire

// ===== tb/sodc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sodc_host_model (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  output logic hung
);
  // ----------------------------------------
  // Core table and bus master
  // ----------------------------------------
  int fEdge[8] = '{7500, 8600, 9800, 10800, 12000, 12900, 13900, 15000};
  int cMin[7] = '{164, 165, 158, 140, 183, 155, 175};
  int cMax[7] = '{12, 16, 19, 0, 36, 6, 19};
  int aMin[7] = '{299, 356, 324, 383, 205, 242, 323};
  int aMax[7] = '{240, 247, 224, 244, 146, 163, 244};
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  // Bounded waits; a stuck slave raises hung
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n = 0;
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge mclk); n++; end while (!hready && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge mclk); n++; end while (!hready && n < 40);
    r = hrdata;
    if (!hready) hung <= 1'b1;
  endtask : xfer
  // Start codes for partial assist, force bits left clear by caller
  function automatic logic [31:0] calWord(input int f);
    int k = 0;
    real p;
    if (f >= 11900 && f <= 12100) return {8'h01, 7'h00, 9'h12c, 5'h00, 3'h4};
    for (int i = 1; i < 7; i++) if (f >= fEdge[i]) k = i;
    p = real'(f - fEdge[k]) / real'(fEdge[k + 1] - fEdge[k]);
    return {8'(int'(cMin[k] - (cMin[k] - cMax[k]) * p)), 7'h00,
      9'(int'(aMin[k] + (aMax[k] - aMin[k]) * p)), 5'h00, 3'(k + 1)};
  endfunction : calWord
endmodule : sodc_host_model
`default_nettype wire

// ===== tb/sodc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sodc_top_sva #(
  parameter logic [15:0] CAL_CYCLES = 16'h0040
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic chipEnable,
  input wire logic powerDown,
  input wire logic divPowerOn,
  input wire logic doublerOn,
  input wire logic [1:0] outASource,
  input wire logic [1:0] outBSource,
  input wire logic [5:0] levelA,
  input wire logic [4:0] stageFactor0,
  input wire logic [4:0] stageFactor1,
  input wire logic [4:0] stageFactor2,
  input wire logic [4:0] stageFactor3,
  input wire logic [9:0] divRatio,
  input wire logic calStart,
  input wire logic calBusy
);
  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;
  always_comb begin
    busyCnt_d = busyCnt_q;
    if (calStart) busyCnt_d = 16'h0001;
    else if (calBusy) busyCnt_d = busyCnt_q + 16'h0001;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) busyCnt_q <= 16'h0000;
    else busyCnt_q <= busyCnt_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Each factor widened first so the product cannot wrap at five bits
  AST_RATIO_PRODUCT: assert property (
    divRatio == 10'(stageFactor0) * 10'(stageFactor1) * 10'(stageFactor2) * 10'(stageFactor3))
    else $error("divider ratio is not the stage product");
  AST_STAGE_RANGE: assert property (
    stageFactor0 == 5'h02 && stageFactor1 inside {5'h01, 5'h02, 5'h03})
    else $error("stage factor outside the segment table");
  AST_DIV_POWER: assert property (
    divPowerOn == (outASource == 2'h0 || outBSource == 2'h0 || outBSource == 2'h2))
    else $error("divider power does not follow source selects");
  AST_DOUBLER_A_ONLY: assert property (doublerOn |-> outASource == 2'h2)
    else $error("doubler on without output A on doubled path");
  AST_LEVEL_FOLD: assert property (!(levelA inside {[6'h20:6'h2f]}))
    else $error("level code 32..47 not folded");
  AST_CE_POWERDOWN: assert property (!chipEnable |=> powerDown)
    else $error("chip enable low did not power down");
  AST_CAL_START_BUSY: assert property (calStart |-> calBusy ##1 calBusy)
    else $error("calibration start without busy");
  AST_BUSY_CAUSE: assert property ($rose(calBusy) |-> calStart)
    else $error("busy rose without start");
  AST_CAL_LENGTH: assert property ($fell(calBusy) |-> busyCnt_q == CAL_CYCLES)
    else $error("calibration length wrong");
endmodule : sodc_top_sva
bind sodc_top sodc_top_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.mclk, .reset, .chipEnable,
  .powerDown, .divPowerOn, .doublerOn, .outASource, .outBSource, .levelA, .stageFactor0,
  .stageFactor1, .stageFactor2, .stageFactor3, .divRatio, .calStart, .calBusy);
`default_nettype wire

// ===== tb/synth_output_divider_cal_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module synth_output_divider_cal_setup_tb;
  import sodc_pkg::*;
  // ----------------------------------------
  // Bench, model tables and checks
  // ----------------------------------------
  localparam int CALN = 4;
  int s1[18] = '{1, 2, 3, 2, 3, 2, 2, 2, 3, 2, 3, 3, 2, 2, 2, 3, 2, 3};
  int s2[18] = '{1, 1, 1, 2, 2, 4, 6, 8, 8, 8, 6, 8, 8, 8, 8, 8, 8, 8};
  int s3[18] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 4, 6, 8, 8, 16, 16};
  int bad_count = 0;
  int n_tests = 0;
  int e1, e2, e3, code, la, lb, f, n;
  logic mclk, reset, chipEnable, hwrite, hreadyout, hresp, hung, powerDown, divPowerOn;
  logic doublerOn, calStart, calBusy, fastRecalOn, coreForce, amplitudeForce, bandForce;
  logic [31:0] haddr, hwdata, hrdata, rd, w;
  logic [1:0] htrans, outASource, outBSource;
  logic [5:0] levelA, levelB;
  sodc_factor_t stageFactor0, stageFactor1, stageFactor2, stageFactor3;
  logic [9:0] divRatio;
  logic [2:0] coreSelect;
  logic [8:0] amplitudeStartCode;
  logic [7:0] bandStartCode;
  sodc_top #(.CAL_CYCLES(16'(CALN))) DUT (.mclk, .reset, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .chipEnable, .powerDown, .divPowerOn, .doublerOn, .outASource, .outBSource, .levelA,
    .levelB, .stageFactor0, .stageFactor1, .stageFactor2, .stageFactor3, .divRatio,
    .calStart, .calBusy, .fastRecalOn, .coreForce, .amplitudeForce, .bandForce,
    .coreSelect, .amplitudeStartCode, .bandStartCode);
  sodc_host_model host (.mclk, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite,
    .hwdata, .hung);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic int fold(input int v);
    return (v >= 32 && v < 48) ? v - 16 : v;
  endfunction : fold
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    for (int i = 0; i < 50000 && hung !== 1'b1; i++) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    chipEnable = 1'b1;
    void'($urandom(32'h0a45da4b));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("rstSrc", 4'h5, {outBSource, outASource});
    chk("rstRatio", 2, divRatio);
    chk("rstDivPwr", 0, divPowerOn);
    chk("busResp", 2'b01, {hresp, hreadyout});
    // Stride 7 visits every code, invalid ones interleaved with valid ones
    for (int c = 0; c < 32; c++) begin
      code = (c * 7) % 32;
      if (code < 18) begin
        e1 = s1[code];
        e2 = s2[code];
        e3 = s3[code];
      end
      host.xfer(1'b1, 8'h08, 32'(code), rd);
      repeat (2) @(negedge mclk);
      chk("factors", {8'd2, 8'(e1), 8'(e2), 8'(e3)}, {8'(stageFactor0), 8'(stageFactor1),
        8'(stageFactor2), 8'(stageFactor3)});
      chk("ratio", 32'(2 * e1 * e2 * e3), divRatio);
      host.xfer(1'b0, 8'h10, 32'h0, rd);
      chk("invalid", code > 17, rd[4]);
      chk("statRatio", 32'(2 * e1 * e2 * e3), rd[25:16]);
      host.xfer(1'b0, 8'h14, 32'h0, rd);
      chk("factReg", {8'(e3), 8'(e2), 8'(e1), 8'd2}, rd);
    end
    for (int a = 0; a < 3; a++) for (int b = 0; b < 3; b++) begin
      la = $urandom_range(50);
      lb = 28 + 2 * (3 * a + b);
      // No phase sync is driven here, so B on the divider stays legal
      w = 32'(a | (b << 2) | ((a == 2) << 4) | (la << 8) | (lb << 16));
      host.xfer(1'b1, 8'h04, w, rd);
      @(negedge mclk);
      chk("divPower", a == 0 || b != 1, divPowerOn);
      chk("doubler", a == 2, doublerOn);
      chk("levels", {8'(fold(la)), 8'(fold(lb))}, {8'(levelA), 8'(levelB)});
      host.xfer(1'b0, 8'h04, 32'h0, rd);
      chk("outReg", w, rd);
    end
    host.xfer(1'b1, 8'h40, 32'hffffffff, rd);
    host.xfer(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 0, rd);
    host.xfer(1'b1, 8'h00, 32'h3c, rd);
    @(negedge mclk);
    chk("forces", 4'hf, {fastRecalOn, coreForce, amplitudeForce, bandForce});
    chk("noStart", 0, calBusy);
    @(posedge mclk) chipEnable <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("pdnPin", 1, powerDown);
    @(posedge mclk) chipEnable <= 1'b1;
    host.xfer(1'b1, 8'h00, 32'h2, rd);
    repeat (2) @(negedge mclk);
    chk("pdnSleep", 1, powerDown);
    host.xfer(1'b1, 8'h00, 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, 8'h10, 32'h0, rd);
      chk("recalFlag", i == 0, rd[5]);
      f = (i == 1) ? 12000 : $urandom_range(15000, 7500);
      w = host.calWord(f);
      host.xfer(1'b1, 8'h0c, w, rd);
      host.xfer(1'b1, 8'h00, 32'h1, rd);
      @(negedge mclk);
      chk("calStart", 1, calStart);
      n = 0;
      while (calBusy && n < 100) begin
        @(negedge mclk);
        n++;
      end
      chk("busyLen", CALN, n);
      chk("startCodes", {w[31:24], 7'h00, w[16:8], 5'h00, w[2:0]},
        {bandStartCode, 7'h00, amplitudeStartCode, 5'h00, coreSelect});
    end
    give_verdict();
  end
endmodule : synth_output_divider_cal_setup_tb
`default_nettype wire
